// ==== src/boot_map_if.sv ====
`default_nettype none
interface boot_map_if;
    logic [vector_place_pkg::SIZE_W-1:0] size_code;
    logic [vector_place_pkg::PC_W-1:0]   fetch_pc;
    logic                                 vector_select;
    logic                                 app_lock_bit;
    logic                                 boot_lock_bit;
    logic [vector_place_pkg::PC_W-1:0]   boot_start;
    logic                                 in_boot;
    logic                                 lock_suppress;

    modport ctrl (
        output size_code,
        output fetch_pc,
        output vector_select,
        output app_lock_bit,
        output boot_lock_bit,
        input  boot_start,
        input  in_boot,
        input  lock_suppress
    );
    modport map (
        input  size_code,
        input  fetch_pc,
        input  vector_select,
        input  app_lock_bit,
        input  boot_lock_bit,
        output boot_start,
        output in_boot,
        output lock_suppress
    );
endinterface
`default_nettype wire

// ==== src/boot_section_map.sv ====
`default_nettype none
module boot_section_map #(
    parameter logic [3:0][vector_place_pkg::PC_W-1:0] BOOT_STARTS = {4{vector_place_pkg::BOOT_START_2K}}
) (
    boot_map_if.map bm
);
    always_comb begin
        // Boot start chosen by the size fuses
        bm.boot_start = BOOT_STARTS[bm.size_code];
        bm.in_boot    = (bm.fetch_pc >= bm.boot_start);
        // Lock bits hold interrupts off in the section away from the vectors
        bm.lock_suppress =
            (bm.vector_select && (bm.app_lock_bit == vector_place_pkg::FUSE_PROGRAMMED)
                && !bm.in_boot)
            || (!bm.vector_select
                && (bm.boot_lock_bit == vector_place_pkg::FUSE_PROGRAMMED)
                && bm.in_boot);
    end
endmodule
`default_nettype wire

// ==== src/interrupt_vector_placement.sv ====
`default_nettype none
// Contract
// - Vector select clear puts the vector table at flash start, set moves it to boot start.
// - The boot section start comes from the boot size fuses, word c00 for a 2K-byte section.
// - A programmed boot reset fuse fetches reset at boot start, else at 000 whatever the select.
// - With a 2K boot section and relocated vectors, vectors run one word each from c01 to c12.
// - Change enable clears itself four cycles after being set, or at once on a select write.
// - Interrupts are blocked from the enable cycle until the instruction after the select write.
// - With no select write, interrupts stay blocked four cycles and are then released.
// - The automatic block never touches the global interrupt enable flag.
// - Vectors in boot with the application lock programmed block interrupts in application code.
// - Vectors in application with the boot lock programmed block interrupts in boot code.
// - A boot reset fuse at one is unprogrammed and at zero is programmed.
// - The table starts at 001 in application space and at boot reset address plus 001 in boot.
module interrupt_vector_placement #(
    parameter logic [3:0][vector_place_pkg::PC_W-1:0] BOOT_STARTS = {4{vector_place_pkg::BOOT_START_2K}}
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [vector_place_pkg::APB_AW-1:0]    paddr,
    input  wire logic [vector_place_pkg::APB_DW-1:0]    pwdata,
    input  wire logic [3:0]                             pstrb,
    output logic      [vector_place_pkg::APB_DW-1:0]    prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic                                   boot_reset_fuse,
    input  wire logic [vector_place_pkg::SIZE_W-1:0]    boot_size_fuses,
    input  wire logic                                   app_lock_bit,
    input  wire logic                                   boot_lock_bit,
    input  wire logic [vector_place_pkg::PC_W-1:0]      fetch_pc,
    input  wire logic                                   instr_done,
    input  wire logic                                   irq_pending,
    input  wire logic [vector_place_pkg::IDX_W-1:0]     irq_index,
    input  wire logic                                   global_irq_enable,
    output logic      [vector_place_pkg::PC_W-1:0]      reset_vector_addr,
    output logic      [vector_place_pkg::PC_W-1:0]      vector_table_start,
    output logic      [vector_place_pkg::PC_W-1:0]      irq_vector_addr,
    output logic                                        irq_block,
    output logic                                        irq_take
);
    function automatic logic reg_hit(input logic [vector_place_pkg::APB_AW-1:0] a,
                                     input logic [vector_place_pkg::APB_AW-1:0] off);
        reg_hit = (a == off);
    endfunction

    boot_map_if bm ();

    logic                                      rst_fuse_m_q;
    logic                                      rst_fuse_q;
    logic [vector_place_pkg::SIZE_W-1:0]       size_m_q;
    logic [vector_place_pkg::SIZE_W-1:0]       size_q;
    logic                                      app_lock_m_q;
    logic                                      app_lock_q;
    logic                                      boot_lock_m_q;
    logic                                      boot_lock_q;
    logic                                      vsel_q;
    logic                                      vce_q;
    logic [vector_place_pkg::ST_COUNT_W-1:0]   count_q;
    vector_place_pkg::chg_state_t              state_q;
    logic                                      access;
    logic                                      gic_hit;
    logic                                      status_hit;
    logic                                      gic_wr;
    logic                                      wdata_vce;
    logic                                      wdata_vsel;
    logic                                      change_block;
    logic [vector_place_pkg::PC_W-1:0]         vec_base;
    logic [vector_place_pkg::APB_DW-1:0]       rd_d;
    logic [vector_place_pkg::APB_DW-1:0]       prdata_q;

    // Fuse and lock pins cross into the core clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_fuse_m_q  <= vector_place_pkg::FUSE_SYNC_RESET;
            rst_fuse_q    <= vector_place_pkg::FUSE_SYNC_RESET;
            size_m_q      <= '0;
            size_q        <= '0;
            app_lock_m_q  <= vector_place_pkg::FUSE_SYNC_RESET;
            app_lock_q    <= vector_place_pkg::FUSE_SYNC_RESET;
            boot_lock_m_q <= vector_place_pkg::FUSE_SYNC_RESET;
            boot_lock_q   <= vector_place_pkg::FUSE_SYNC_RESET;
        end else begin
            rst_fuse_m_q  <= boot_reset_fuse;
            rst_fuse_q    <= rst_fuse_m_q;
            size_m_q      <= boot_size_fuses;
            size_q        <= size_m_q;
            app_lock_m_q  <= app_lock_bit;
            app_lock_q    <= app_lock_m_q;
            boot_lock_m_q <= boot_lock_bit;
            boot_lock_q   <= boot_lock_m_q;
        end
    end

    assign bm.size_code     = size_q;
    assign bm.fetch_pc      = fetch_pc;
    assign bm.vector_select = vsel_q;
    assign bm.app_lock_bit  = app_lock_q;
    assign bm.boot_lock_bit = boot_lock_q;

    boot_section_map #(
        .BOOT_STARTS (BOOT_STARTS)
    ) u_map (
        .bm (bm.map)
    );

    // APB decode, zero wait states
    assign access     = psel && penable;
    assign gic_hit    = reg_hit(paddr, vector_place_pkg::GIC_OFFSET);
    assign status_hit = reg_hit(paddr, vector_place_pkg::STATUS_OFFSET);
    assign gic_wr     = access && pwrite && gic_hit && pstrb[0];
    assign wdata_vce  = pwdata[vector_place_pkg::VCE_BIT];
    assign wdata_vsel = pwdata[vector_place_pkg::VSEL_BIT];
    assign pready     = 1'b1;
    assign pslverr    = access && !(gic_hit || status_hit);

    // Change procedure state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= vector_place_pkg::CHG_IDLE;
        end else if (gic_wr && wdata_vce) begin
            state_q <= vector_place_pkg::CHG_OPEN;
        end else begin
            unique case (state_q)
                vector_place_pkg::CHG_IDLE: begin
                    state_q <= vector_place_pkg::CHG_IDLE;
                end
                vector_place_pkg::CHG_OPEN: begin
                    if (gic_wr) begin
                        state_q <= vector_place_pkg::CHG_HOLD;
                    end else if (count_q == '0) begin
                        state_q <= vector_place_pkg::CHG_IDLE;
                    end
                end
                vector_place_pkg::CHG_HOLD: begin
                    if (instr_done) begin
                        state_q <= vector_place_pkg::CHG_IDLE;
                    end
                end
                default: begin
                    state_q <= vector_place_pkg::CHG_IDLE;
                end
            endcase
        end
    end

    // Change enable bit and its four-cycle window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vce_q   <= vector_place_pkg::GIC_RESET[vector_place_pkg::VCE_BIT];
            count_q <= '0;
        end else if (gic_wr && wdata_vce) begin
            vce_q   <= 1'b1;
            count_q <= vector_place_pkg::WINDOW_LOAD;
        end else if (vce_q && gic_wr) begin
            vce_q   <= 1'b0;
            count_q <= '0;
        end else if (vce_q) begin
            if (count_q == '0) begin
                vce_q <= 1'b0;
            end else begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // Vector select, writable only inside the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsel_q <= vector_place_pkg::GIC_RESET[vector_place_pkg::VSEL_BIT];
        end else if (gic_wr && !wdata_vce && vce_q) begin
            vsel_q <= wdata_vsel;
        end
    end

    // Interrupt blocking, global enable left untouched
    assign change_block = (gic_wr && wdata_vce)
                          || (state_q != vector_place_pkg::CHG_IDLE);
    assign irq_block = change_block || bm.lock_suppress;
    assign irq_take  = irq_pending && global_irq_enable && !irq_block;

    // Vector placement
    assign vec_base = vsel_q ? bm.boot_start : vector_place_pkg::APP_START;
    assign vector_table_start = vec_base + vector_place_pkg::VEC_TABLE_OFFSET;
    assign irq_vector_addr = vec_base + {{(vector_place_pkg::PC_W-vector_place_pkg::IDX_W){1'b0}},
                             irq_index};
    assign reset_vector_addr = (rst_fuse_q == vector_place_pkg::FUSE_PROGRAMMED)
                               ? bm.boot_start
                               : vector_place_pkg::APP_RESET_ADDR;

    // Read data
    always_comb begin
        rd_d = '0;
        if (gic_hit) begin
            rd_d[vector_place_pkg::VCE_BIT]  = vce_q;
            rd_d[vector_place_pkg::VSEL_BIT] = vsel_q;
        end else if (status_hit) begin
            rd_d[vector_place_pkg::ST_BLOCK_BIT]    = change_block;
            rd_d[vector_place_pkg::ST_SUPPRESS_BIT] = bm.lock_suppress;
            rd_d[vector_place_pkg::ST_IN_BOOT_BIT]  = bm.in_boot;
            rd_d[vector_place_pkg::ST_HOLD_BIT]     = (state_q == vector_place_pkg::CHG_HOLD);
            rd_d[vector_place_pkg::ST_COUNT_LSB +: vector_place_pkg::ST_COUNT_W] = count_q;
            rd_d[vector_place_pkg::ST_START_LSB +: vector_place_pkg::PC_W] = bm.boot_start;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_d;
        end
    end
    assign prdata = prdata_q;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_open;
        gic_wr && wdata_vce;
    endsequence

    sequence s_select_write;
        vce_q && gic_wr && !wdata_vce;
    endsequence

    property p_window_timeout;
        s_open ##1 (!gic_wr) [*4] |=> !vce_q && (state_q == vector_place_pkg::CHG_IDLE);
    endproperty
    a_window_timeout: assert property (p_window_timeout)
        else $error("change window did not close after four cycles");

    property p_window_held;
        s_open ##1 (!gic_wr) [*3] |-> vce_q && irq_block;
    endproperty
    a_window_held: assert property (p_window_held)
        else $error("change window closed early");

    property p_early_clear;
        s_select_write |=> !vce_q;
    endproperty
    a_early_clear: assert property (p_early_clear)
        else $error("change enable not cleared by select write");

    property p_block_start;
        s_open |-> irq_block && !irq_take;
    endproperty
    a_block_start: assert property (p_block_start)
        else $error("interrupts not blocked in enable cycle");

    property p_block_after_select;
        s_select_write ##1 (!instr_done && !gic_wr) [*2] |-> irq_block;
    endproperty
    a_block_after_select: assert property (p_block_after_select)
        else $error("block released before following instruction");

    property p_release_after_instr;
        (state_q == vector_place_pkg::CHG_HOLD && instr_done && !gic_wr) ##1 !gic_wr
            |-> !change_block;
    endproperty
    a_release_after_instr: assert property (p_release_after_instr)
        else $error("block held after following instruction");

    property p_select_taken;
        s_select_write |=> vsel_q == $past(wdata_vsel);
    endproperty
    a_select_taken: assert property (p_select_taken)
        else $error("vector select not taken in window");

    property p_select_guard;
        (gic_wr && !vce_q) |=> $stable(vsel_q);
    endproperty
    a_select_guard: assert property (p_select_guard)
        else $error("vector select changed outside window");

    property p_ibit;
        irq_take == (irq_pending && global_irq_enable && !irq_block);
    endproperty
    a_ibit: assert property (p_ibit)
        else $error("global enable altered by block");

    property p_table_base;
        vector_table_start == (vsel_q ? bm.boot_start + 12'h001 : 12'h001);
    endproperty
    a_table_base: assert property (p_table_base)
        else $error("vector table start wrong");

    property p_last_vector;
        (vsel_q && bm.boot_start == 12'hc00 && irq_index == 5'h12) |-> irq_vector_addr == 12'hc12;
    endproperty
    a_last_vector: assert property (p_last_vector)
        else $error("last vector misplaced");

    property p_reset_vector;
        reset_vector_addr == (rst_fuse_q ? 12'h000 : bm.boot_start);
    endproperty
    a_reset_vector: assert property (p_reset_vector)
        else $error("reset vector wrong for fuse");

    property p_app_lock;
        (vsel_q && !app_lock_q && !bm.in_boot) |-> irq_block;
    endproperty
    a_app_lock: assert property (p_app_lock)
        else $error("app lock did not suppress");

    property p_boot_lock;
        (!vsel_q && !boot_lock_q && bm.in_boot) |-> irq_block;
    endproperty
    a_boot_lock: assert property (p_boot_lock)
        else $error("boot lock did not suppress");
endmodule
`default_nettype wire

// ==== src/vector_place_pkg.sv ====
`default_nettype none
package vector_place_pkg;
    // Widths
    localparam int PC_W        = 12;
    localparam int IDX_W       = 5;
    localparam int SIZE_W      = 2;
    localparam int APB_AW      = 12;
    localparam int APB_DW      = 32;

    // Register byte offsets
    localparam logic [APB_AW-1:0] GIC_OFFSET    = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h004;

    // Control register fields
    localparam int VCE_BIT  = 0;
    localparam int VSEL_BIT = 1;
    localparam logic [1:0] GIC_RESET = 2'h0;

    // Status register fields
    localparam int ST_BLOCK_BIT    = 0;
    localparam int ST_SUPPRESS_BIT = 1;
    localparam int ST_IN_BOOT_BIT  = 2;
    localparam int ST_HOLD_BIT     = 3;
    localparam int ST_COUNT_LSB    = 4;
    localparam int ST_COUNT_W      = 2;
    localparam int ST_START_LSB    = 8;

    // Change window length in core cycles
    localparam int CHANGE_WINDOW_CYCLES = 4;
    localparam logic [ST_COUNT_W-1:0] WINDOW_LOAD = 2'h3;

    // Addresses in flash words
    localparam logic [PC_W-1:0] APP_RESET_ADDR   = 12'h000;
    localparam logic [PC_W-1:0] APP_START        = 12'h000;
    localparam logic [PC_W-1:0] VEC_TABLE_OFFSET = 12'h001;
    localparam logic [PC_W-1:0] BOOT_START_2K    = 12'hc00;

    // Vector indices, one word each
    localparam logic [IDX_W-1:0] EXTERNAL_IRQ0_VECTOR        = 5'h01;
    localparam logic [IDX_W-1:0] STORE_PROGRAM_READY_VECTOR  = 5'h12;

    // Fuse and lock encoding
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic FUSE_SYNC_RESET = 1'b1;

    typedef enum logic [1:0] {
        CHG_IDLE,
        CHG_OPEN,
        CHG_HOLD
    } chg_state_t;
endpackage
`default_nettype wire

// ==== verif/core_model.sv ====
`default_nettype none
module core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  gap,
    input  wire logic [11:0] pc_in,
    input  wire logic        irq_in,
    input  wire logic [4:0]  idx_in,
    input  wire logic        gie_in,
    output logic      [11:0] fetch_pc,
    output logic             instr_done,
    output logic             irq_pending,
    output logic      [4:0]  irq_index,
    output logic             global_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_q;

    // One completed instruction every gap cycles, none while gap is zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q      <= 4'h0;
            instr_done <= 1'b0;
        end else begin
            cnt_q      <= (gap == 4'h0 || cnt_q + 4'h1 >= gap) ? 4'h0 : cnt_q + 4'h1;
            instr_done <= (gap != 4'h0) && (cnt_q + 4'h1 >= gap);
        end
    end

    // Fetch address and interrupt request as the core registers them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_pc          <= 12'h000;
            irq_pending       <= 1'b0;
            irq_index         <= 5'h00;
            global_irq_enable <= 1'b0;
        end else begin
            fetch_pc          <= pc_in;
            irq_pending       <= irq_in;
            irq_index         <= idx_in;
            global_irq_enable <= gie_in;
        end
    end
endmodule
`default_nettype wire

// ==== verif/interrupt_vector_placement_tb.sv ====
`default_nettype none
module interrupt_vector_placement_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0][11:0] BS = {12'h900, 12'ha00, 12'hb00, 12'hc00};

    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        boot_reset_fuse;
    logic [1:0]  boot_size_fuses;
    logic        app_lock_bit;
    logic        boot_lock_bit;
    logic [11:0] fetch_pc;
    logic        instr_done;
    logic        irq_pending;
    logic [4:0]  irq_index;
    logic        global_irq_enable;
    logic [11:0] reset_vector_addr;
    logic [11:0] vector_table_start;
    logic [11:0] irq_vector_addr;
    logic        irq_block;
    logic        irq_take;
    logic [3:0]  gap;
    logic [11:0] pc_in;
    logic        irq_in;
    logic [4:0]  idx_in;
    logic        gie_in;
    logic [31:0] rd;
    logic        er;
    int          err_count = 0;
    int          check_count = 0;

    always #5 pclk = ~pclk;

    interrupt_vector_placement #(.BOOT_STARTS(BS)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_reset_fuse(boot_reset_fuse),
        .boot_size_fuses(boot_size_fuses), .app_lock_bit(app_lock_bit),
        .boot_lock_bit(boot_lock_bit), .fetch_pc(fetch_pc), .instr_done(instr_done),
        .irq_pending(irq_pending), .irq_index(irq_index),
        .global_irq_enable(global_irq_enable), .reset_vector_addr(reset_vector_addr),
        .vector_table_start(vector_table_start), .irq_vector_addr(irq_vector_addr),
        .irq_block(irq_block), .irq_take(irq_take)
    );

    core_model core_u (
        .pclk(pclk), .presetn(presetn), .gap(gap), .pc_in(pc_in), .irq_in(irq_in),
        .idx_in(idx_in), .gie_in(gie_in), .fetch_pc(fetch_pc), .instr_done(instr_done),
        .irq_pending(irq_pending), .irq_index(irq_index),
        .global_irq_enable(global_irq_enable)
    );

    task automatic summarize();
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bail();
        err_count++;
        $display("[ERR] %0t ns: wait limit reached", $time);
        summarize();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic half(input int n);
        repeat (n) @(negedge pclk);
    endtask

    // One APB transfer; returns at the edge that completed it
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) bail();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic move(input logic v);
        xfer(1'b1, 12'h000, 32'h1);
        xfer(1'b1, 12'h000, {30'h0, v, 1'b0});
    endtask

    task automatic vec_table(input logic [11:0] base);
        for (int i = 1; i <= 18; i++) begin
            @(posedge pclk);
            idx_in <= i[4:0];
            half(2);
            check(32'(irq_vector_addr), 32'(base + i[11:0]));
        end
        check(32'(vector_table_start), 32'(base + 12'h001));
    endtask

    task automatic pins(input logic al, input logic bl, input logic [11:0] pc);
        @(posedge pclk);
        app_lock_bit  <= al;
        boot_lock_bit <= bl;
        pc_in         <= pc;
        half(4);
    endtask

    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        boot_reset_fuse = 1'b1;
        boot_size_fuses = 2'h0;
        app_lock_bit = 1'b1;
        boot_lock_bit = 1'b1;
        gap = 4'h0;
        pc_in = 12'h100;
        irq_in = 1'b1;
        idx_in = 5'h01;
        gie_in = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        half(3);
        // Reset state and register map
        xfer(1'b0, 12'h000, 32'h0);
        check(rd, 32'(vector_place_pkg::GIC_RESET));
        check(32'(vector_table_start), 32'h001);
        check(32'(reset_vector_addr), 32'h000);
        xfer(1'b1, 12'h008, 32'h1);
        check(32'(er), 32'h1);
        half(1);
        check(32'(irq_block), 32'h0);
        xfer(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        check(32'(er), 32'h1);
        // Select written without an open window
        xfer(1'b1, 12'h000, 32'h2);
        xfer(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        // Boot start per size code, reset placement per fuse
        @(posedge pclk);
        boot_reset_fuse <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            @(posedge pclk);
            boot_size_fuses <= c[1:0];
            half(4);
            check(32'(reset_vector_addr), 32'(BS[c]));
            xfer(1'b0, 12'h004, 32'h0);
            check(32'(rd[19:8]), 32'(BS[c]));
        end
        @(posedge pclk);
        boot_size_fuses <= 2'h0;
        boot_reset_fuse <= 1'b1;
        half(4);
        check(32'(reset_vector_addr), 32'h000);
        // Window opened and left to expire
        check(32'(irq_take), 32'h1);
        xfer(1'b1, 12'h000, 32'h1);
        half(1);
        check(32'({irq_block, irq_take}), 32'h2);
        half(3);
        check(32'(irq_block), 32'h1);
        half(1);
        check(32'({irq_block, irq_take}), 32'h1);
        xfer(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        // Move vectors to the boot section
        move(1'b1);
        xfer(1'b0, 12'h000, 32'h0);
        check(rd, 32'h2);
        half(1);
        check(32'(irq_block), 32'h1);
        @(posedge pclk);
        gap <= 4'h3;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (instr_done !== 1'b1 && n < 20);
        if (instr_done !== 1'b1) bail();
        check(32'(irq_block), 32'h1);
        half(1);
        check(32'(irq_block), 32'h0);
        check(32'(reset_vector_addr), 32'h000);
        vec_table(12'hc00);
        // Application lock with vectors in boot
        pins(1'b0, 1'b1, 12'h100);
        check(32'(irq_block), 32'h1);
        pins(1'b0, 1'b1, 12'hc10);
        check(32'(irq_block), 32'h0);
        pins(1'b1, 1'b1, 12'h100);
        // Move vectors back to application space
        move(1'b0);
        half(1);
        check(32'(irq_block), 32'h1);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (irq_block !== 1'b0 && n < 30);
        if (irq_block !== 1'b0) bail();
        check(32'(irq_block), 32'h0);
        vec_table(12'h000);
        // Boot lock with vectors in application space
        pins(1'b1, 1'b0, 12'hc10);
        check(32'(irq_block), 32'h1);
        pins(1'b1, 1'b0, 12'h100);
        check(32'(irq_block), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
